/* File: timer_pkg.sv */
package timer_pkg;
  // Data and register port widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register offsets (index on the register port)
  localparam logic [3:0] ADDR_COUNT       = 4'h0;
  localparam logic [3:0] ADDR_PERIOD      = 4'h1;
  localparam logic [3:0] ADDR_CONTROL     = 4'h2;
  localparam logic [3:0] ADDR_FLAGS       = 4'h3;
  localparam logic [3:0] ADDR_FLAG_CLEAR  = 4'h4;
  localparam logic [3:0] ADDR_FLAG_ENABLE = 4'h5;

  // Control register fields
  localparam int CTRL_PRESCALE_LSB = 0;
  localparam int CTRL_PRESCALE_W   = 2;
  localparam int CTRL_RUN_BIT      = 2;
  localparam int CTRL_POST_LSB     = 3;
  localparam int CTRL_POST_W       = 4;
  localparam int CTRL_USED_W       = 7;

  // Flag register layout
  localparam int FLAG_MATCH_BIT = 1;

  // Reset values
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET  = 8'hff;
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;

  // Scaler geometry
  localparam int INSTR_DIV = 4;
  localparam int PRE_W     = 6;
  localparam int POST_W    = 4;

  // Prescale select codes
  localparam logic [1:0] PRESCALE_1  = 2'h0;
  localparam logic [1:0] PRESCALE_4  = 2'h1;
  localparam int         RATIO_1     = 1;
  localparam int         RATIO_4     = 4;
  localparam int         RATIO_16    = 16;
endpackage

/* File: scaler_if.sv */
interface scaler_if;
  logic                             clear;
  logic                             run;
  logic [timer_pkg::CTRL_PRESCALE_W-1:0] prescale_sel;
  logic                             tick;
  logic                             match;
  logic [timer_pkg::POST_W-1:0]     post_sel;
  logic                             post_done;

  modport ctrl (
    output clear,
    output run,
    output prescale_sel,
    output match,
    output post_sel,
    input  tick,
    input  post_done
  );

  modport pre (
    input  clear,
    input  run,
    input  prescale_sel,
    output tick
  );

  modport post (
    input  clear,
    input  match,
    input  post_sel,
    output post_done
  );
endinterface

/* File: prescaler.sv */
module prescaler #(
  parameter int PRE_W = timer_pkg::PRE_W
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Scaler link
  scaler_if.pre     sc
);

  // Clocks per count step: instruction divide times prescale ratio
  function automatic logic [PRE_W-1:0] step_limit(input logic [1:0] sel);
    int ratio;
    ratio = timer_pkg::RATIO_16;
    if (sel == timer_pkg::PRESCALE_1) begin
      ratio = timer_pkg::RATIO_1;
    end else if (sel == timer_pkg::PRESCALE_4) begin
      ratio = timer_pkg::RATIO_4;
    end
    return PRE_W'(timer_pkg::INSTR_DIV * ratio - 1);
  endfunction

  logic [PRE_W-1:0] cnt_reg;
  logic [PRE_W-1:0] limit;

  assign limit   = step_limit(sc.prescale_sel);
  assign sc.tick = sc.run && !sc.clear && (cnt_reg == limit);

  always_ff @(posedge clk) begin
    if (reset || sc.clear) begin
      cnt_reg <= '0;
    end else if (sc.run) begin
      if (cnt_reg == limit) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= PRE_W'(cnt_reg + 1'b1);
      end
    end
  end

  property p_pre_clear;
    @(posedge clk) (reset || sc.clear) |=> (cnt_reg == '0);
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("prescaler not cleared");

  property p_pre_ratio;
    @(posedge clk) disable iff (reset)
      (sc.tick && sc.prescale_sel == timer_pkg::PRESCALE_4)
        |-> (cnt_reg == PRE_W'(15));
  endproperty
  a_pre_ratio: assert property (p_pre_ratio)
    else $error("prescale 1:4 tick at wrong count");

endmodule // prescaler

/* File: postscaler.sv */
module postscaler #(
  parameter int POST_W = timer_pkg::POST_W
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Scaler link
  scaler_if.post    sc
);

  logic [POST_W-1:0] cnt_reg;

  // Ratio is post_sel + 1, so 1:1 up to 1:16
  assign sc.post_done = sc.match && !sc.clear && (cnt_reg == sc.post_sel);

  always_ff @(posedge clk) begin
    if (reset || sc.clear) begin
      cnt_reg <= '0;
    end else if (sc.match) begin
      if (cnt_reg == sc.post_sel) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= POST_W'(cnt_reg + 1'b1);
      end
    end
  end

  property p_post_wrap;
    @(posedge clk) disable iff (reset)
      sc.post_done |=> (cnt_reg == '0);
  endproperty
  a_post_wrap: assert property (p_post_wrap)
    else $error("postscaler did not restart after completion");

  property p_post_clear;
    @(posedge clk) (reset || sc.clear) |=> (cnt_reg == '0);
  endproperty
  a_post_clear: assert property (p_post_clear)
    else $error("postscaler not cleared");

endmodule // postscaler

/* File: period_timer.sv */
module period_timer (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // Register port
  input  wire logic [timer_pkg::ADDR_W-1:0] addr,
  input  wire logic [timer_pkg::DATA_W-1:0] wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [timer_pkg::DATA_W-1:0] rdata,
  // Interrupt
  output logic                              irq,
  // Time base to capture/compare unit and serial port
  output logic      [timer_pkg::DATA_W-1:0] timer_count,
  output logic                              period_match
);

  scaler_if sc ();

  logic [7:0] count_reg;
  logic [7:0] period_reg;
  logic [6:0] control_reg;
  logic [7:0] flags_reg;
  logic [7:0] enable_reg;
  logic [7:0] rdata_reg;
  logic       match_reg;
  logic       wr_count;
  logic       wr_period;
  logic       wr_control;
  logic       wr_clear;
  logic       wr_enable;
  logic       wrap;

  function automatic logic hit(input logic strobe,
                               input logic [3:0] a,
                               input logic [3:0] target);
    return strobe && (a == target);
  endfunction

  assign wr_count   = hit(wr, addr, timer_pkg::ADDR_COUNT);
  assign wr_period  = hit(wr, addr, timer_pkg::ADDR_PERIOD);
  assign wr_control = hit(wr, addr, timer_pkg::ADDR_CONTROL);
  assign wr_clear   = hit(wr, addr, timer_pkg::ADDR_FLAG_CLEAR);
  assign wr_enable  = hit(wr, addr, timer_pkg::ADDR_FLAG_ENABLE);

  // Scaler controls
  assign sc.clear        = wr_count || wr_control;
  assign sc.run          = control_reg[timer_pkg::CTRL_RUN_BIT];
  assign sc.prescale_sel =
    control_reg[timer_pkg::CTRL_PRESCALE_LSB +: timer_pkg::CTRL_PRESCALE_W];
  assign sc.post_sel     =
    control_reg[timer_pkg::CTRL_POST_LSB +: timer_pkg::CTRL_POST_W];

  assign wrap     = sc.tick && (count_reg == period_reg);
  assign sc.match = wrap;

  prescaler #(
    .PRE_W (timer_pkg::PRE_W)
  ) u_prescaler (
    .clk   (clk),
    .reset (reset),
    .sc    (sc.pre)
  );

  postscaler #(
    .POST_W (timer_pkg::POST_W)
  ) u_postscaler (
    .clk   (clk),
    .reset (reset),
    .sc    (sc.post)
  );

  // Counter
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= timer_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_reg <= wdata;
    end else if (wrap) begin
      count_reg <= timer_pkg::COUNT_RESET;
    end else if (sc.tick) begin
      count_reg <= 8'(count_reg + 1'b1);
    end
  end

  // Period register
  always_ff @(posedge clk) begin
    if (reset) begin
      period_reg <= timer_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      period_reg <= wdata;
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (reset) begin
      control_reg <= timer_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control_reg <= wdata[timer_pkg::CTRL_USED_W-1:0];
    end
  end

  // Match pulse, one cycle after the wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= wrap;
    end
  end

  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= timer_pkg::FLAGS_RESET;
    end else begin
      if (wr_clear && wdata[timer_pkg::FLAG_MATCH_BIT]) begin
        flags_reg[timer_pkg::FLAG_MATCH_BIT] <= 1'b0;
      end
      if (sc.post_done) begin
        flags_reg[timer_pkg::FLAG_MATCH_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= 8'h00;
    end else if (wr_enable) begin
      enable_reg <= wdata & 8'h02;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !rd) begin
      rdata_reg <= 8'h00;
    end else begin
      case (addr)
        timer_pkg::ADDR_COUNT:       rdata_reg <= count_reg;
        timer_pkg::ADDR_PERIOD:      rdata_reg <= period_reg;
        timer_pkg::ADDR_CONTROL:     rdata_reg <= {1'b0, control_reg};
        timer_pkg::ADDR_FLAGS:       rdata_reg <= flags_reg;
        timer_pkg::ADDR_FLAG_ENABLE: rdata_reg <= enable_reg;
        default:                     rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rdata        = rdata_reg;
  assign irq          = |(flags_reg & enable_reg);
  assign timer_count  = count_reg;
  assign period_match = match_reg;

  // Checks
  sequence s_quiet;
    !wr_clear;
  endsequence

  property p_reset_values;
    @(posedge clk) reset |=> (count_reg == 8'h00) && (period_reg == 8'hff);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values of counter or period wrong");

  property p_increment;
    @(posedge clk) disable iff (reset)
      (sc.tick && count_reg != period_reg && !wr_count)
        |=> (count_reg == 8'($past(count_reg) + 1'b1));
  endproperty
  a_increment: assert property (p_increment)
    else $error("counter did not step by one");

  property p_wrap;
    @(posedge clk) disable iff (reset)
      (wrap && !wr_count) |=> (count_reg == 8'h00) && period_match;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap with match pulse");

  property p_stopped;
    @(posedge clk) disable iff (reset)
      (!sc.run && !wr_count) |=> $stable(count_reg);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_ctrl_write_keeps;
    @(posedge clk) disable iff (reset)
      wr_control |=> (count_reg == $past(count_reg));
  endproperty
  a_ctrl_write_keeps: assert property (p_ctrl_write_keeps)
    else $error("control write changed counter");

  property p_flag_set;
    @(posedge clk) disable iff (reset)
      sc.post_done |=> flags_reg[timer_pkg::FLAG_MATCH_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set on postscaler completion");

  property p_flag_sticky;
    @(posedge clk) disable iff (reset)
      (flags_reg[timer_pkg::FLAG_MATCH_BIT] && !wr_clear)
        ##1 (s_quiet [*3]) |-> flags_reg[timer_pkg::FLAG_MATCH_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without clear");

  property p_match_source;
    @(posedge clk) disable iff (reset)
      period_match |-> $past(wrap);
  endproperty
  a_match_source: assert property (p_match_source)
    else $error("match pulse without wrap");

  property p_irq;
    @(posedge clk) disable iff (reset)
      irq |-> (flags_reg[timer_pkg::FLAG_MATCH_BIT]
               && enable_reg[timer_pkg::FLAG_MATCH_BIT]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enabled flag");

  // Register, scaler and time base checks
  sequence s_no_tick;
    !sc.tick [*3];
  endsequence

  property p_period_hold;
    @(posedge clk) disable iff (reset)
      !wr_period |=> $stable(period_reg);
  endproperty
  a_period_hold: assert property (p_period_hold)
    else $error("period changed without a write");

  property p_period_write;
    @(posedge clk) disable iff (reset)
      wr_period |=> (period_reg == $past(wdata));
  endproperty
  a_period_write: assert property (p_period_write)
    else $error("period write not stored");

  property p_count_write;
    @(posedge clk) disable iff (reset)
      wr_count |=> (count_reg == $past(wdata));
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("counter write not stored");

  property p_read_count;
    @(posedge clk) disable iff (reset)
      (rd && addr == timer_pkg::ADDR_COUNT)
        |=> (rdata == $past(count_reg));
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("counter read returned wrong data");

  property p_read_period;
    @(posedge clk) disable iff (reset)
      (rd && addr == timer_pkg::ADDR_PERIOD)
        |=> (rdata == $past(period_reg));
  endproperty
  a_read_period: assert property (p_read_period)
    else $error("period read returned wrong data");

  property p_scaler_restart;
    @(posedge clk) disable iff (reset)
      sc.clear |=> s_no_tick;
  endproperty
  a_scaler_restart: assert property (p_scaler_restart)
    else $error("scaler stepped right after a clear");

  property p_run_gate;
    @(posedge clk) disable iff (reset)
      !sc.run |-> !sc.tick;
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("step while the run bit is clear");

  property p_match_pulse;
    @(posedge clk) disable iff (reset)
      period_match |=> !period_match;
  endproperty
  a_match_pulse: assert property (p_match_pulse)
    else $error("match pulse longer than one cycle");

  property p_flag_clear;
    @(posedge clk) disable iff (reset)
      (wr_clear && wdata[timer_pkg::FLAG_MATCH_BIT] && !sc.post_done)
        |=> !flags_reg[timer_pkg::FLAG_MATCH_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by software");

  property p_irq_raise;
    @(posedge clk) disable iff (reset)
      (flags_reg[timer_pkg::FLAG_MATCH_BIT]
       && enable_reg[timer_pkg::FLAG_MATCH_BIT]) |-> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled flag without interrupt");

endmodule // period_timer

/* File: time_base_sink.sv */
module time_base_sink (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // Time base from the timer
  input  wire logic [timer_pkg::DATA_W-1:0] timer_count,
  input  wire logic                         period_match,
  // Observed results
  output logic      [15:0]                  match_total,
  output logic                              shift_clk,
  output logic                              pwm_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Each match steps the serial shift clock
  always_ff @(posedge clk) begin
    if (reset) begin
      match_total <= 16'h0000;
      shift_clk   <= 1'b0;
    end else if (period_match) begin
      match_total <= match_total + 16'h0001;
      shift_clk   <= ~shift_clk;
    end
  end

  // Duty of one count: high only while the count sits at zero
  assign pwm_out = (timer_count < 8'h01);
endmodule // time_base_sink

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        reset;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq;
  logic [7:0]  timer_count;
  logic        period_match;
  logic [15:0] match_total;
  logic [15:0] base;
  logic        pwm_out;
  logic        shift_clk;
  logic        shift_base;
  int          fail_count;
  int          num_checks;
  int          cycles;
  int          n;
  int          ratio [4] = '{1, 4, 16, 16};

  period_timer period_timer_inst (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .timer_count(timer_count),
    .period_match(period_match));

  time_base_sink time_base_sink_inst (
    .clk(clk), .reset(reset), .timer_count(timer_count),
    .period_match(period_match), .match_total(match_total),
    .shift_clk(shift_clk), .pwm_out(pwm_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_n(input int got, input int lo, input int hi,
                         input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %0d", $time, what, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8(rdata, exp, what);
  endtask

  // Waits for a match pulse, returns cycles waited
  task automatic wait_match(output int w);
    w = 0;
    do begin
      @(posedge clk);
      #1;
      w++;
    end while (period_match !== 1'b1 && w < 4000);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 4'h0;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    reg_rd(timer_pkg::ADDR_COUNT, 8'h00, "count reset");
    reg_rd(timer_pkg::ADDR_PERIOD, 8'hff, "period reset");
    reg_rd(timer_pkg::ADDR_CONTROL, 8'h00, "control reset");
    reg_wr(timer_pkg::ADDR_FLAGS, 8'hff);
    reg_rd(timer_pkg::ADDR_FLAGS, 8'h00, "flags read only");
    reg_rd(4'h6, 8'h00, "unmapped");
    check8({7'h00, irq}, 8'h00, "irq idle");
    reg_wr(timer_pkg::ADDR_PERIOD, 8'h02);
    reg_rd(timer_pkg::ADDR_PERIOD, 8'h02, "period rw");
    reg_wr(timer_pkg::ADDR_FLAG_ENABLE, 8'h02);
    // Three steps per period, four clocks per step times the ratio
    for (int i = 0; i < 4; i++) begin
      reg_wr(timer_pkg::ADDR_CONTROL, 8'(4 + i));
      wait_match(n);
      wait_match(n);
      check_n(n, 12 * ratio[i], 12 * ratio[i], "interval");
      check8(timer_count, 8'h00, "wrap");
      check8({7'h00, pwm_out}, 8'h01, "pwm base");
    end
    check8({7'h00, irq}, 8'h01, "irq raised");
    wait_match(n);
    reg_rd(timer_pkg::ADDR_FLAGS, 8'h02, "flag sticky");
    reg_wr(timer_pkg::ADDR_FLAG_ENABLE, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check8({7'h00, irq}, 8'h00, "irq masked");
    reg_wr(timer_pkg::ADDR_FLAG_ENABLE, 8'h02);
    reg_wr(timer_pkg::ADDR_CONTROL, 8'h00);
    reg_wr(timer_pkg::ADDR_FLAG_CLEAR, 8'h02);
    reg_rd(timer_pkg::ADDR_FLAGS, 8'h00, "flag cleared");
    check8({7'h00, irq}, 8'h00, "irq cleared");
    // Stopped count holds; a starting control write keeps it
    reg_wr(timer_pkg::ADDR_COUNT, 8'h01);
    reg_rd(timer_pkg::ADDR_COUNT, 8'h01, "count rw");
    repeat (40) @(posedge clk);
    reg_wr(timer_pkg::ADDR_CONTROL, 8'h04);
    reg_rd(timer_pkg::ADDR_COUNT, 8'h01, "count held");
    // Postscale 1:3
    base = match_total;
    shift_base = shift_clk;
    reg_wr(timer_pkg::ADDR_CONTROL, 8'h14);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 1000);
    repeat (2) @(posedge clk);
    #1;
    check_n(int'(match_total - base), 3, 3, "postscale");
    check8({7'h00, shift_clk}, {7'h00, ~shift_base}, "shift clk");
    // Count write restarts the 1:16 prescaler
    reg_wr(timer_pkg::ADDR_CONTROL, 8'h06);
    repeat (30) @(posedge clk);
    reg_wr(timer_pkg::ADDR_COUNT, 8'h00);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (timer_count === 8'h00 && n < 200);
    check_n(n, 63, 65, "prescale cleared");
    // Reset in mid-run
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    reg_rd(timer_pkg::ADDR_COUNT, 8'h00, "count rerset");
    reg_rd(timer_pkg::ADDR_PERIOD, 8'hff, "period reset");
    summarize();
  end
endmodule // testbench
